// ---- logic/ifr_image_fifo_readout.sv ----
// Summary of operation
// - FIFO data read returns oldest byte and lowers the count by one.
// - Ready condition drops once a read takes the count below threshold.
// - Reading an empty FIFO returns the last valid byte, count unchanged.
// - Envelope start clears FIFO; leftover bytes raise the error flag.
// - Overflow during envelope raises sticky error flag until cleared.
// - Control bit 5 sets interrupt pin polarity, bit 4 request polarity.
// - Burst field: 00 off with request pin floating, else 8/16/32 bytes.
// - Writing 1 to control bit 0 empties FIFO; reads back as 0.
// - Each of six mask bits lets its status source reach interrupt.
// - Writing 1 to clear bits 5..2 clears the matching status flag.
// - Not-empty bit set makes threshold one byte, count field ignored.
// - Otherwise threshold is the seven-bit field times sixteen bytes.
// - Read-only sixteen-bit count register shows bytes in the FIFO.
// - With DMA on, request asserts when count reaches threshold.
// - Request drops once the first byte of a burst is read.
// - Burst ending empty after frame end raises end-of-transfer IRQ.
// - Short final burst is padded with dummy bytes.
// - Ready flag is count at least threshold; threshold is one between frames.
// - Interrupt flag active when any source is set with its mask bit.
`timescale 1ns/100ps
`include "ifr_map.svh"

module ifr_fifo
  import ifr_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int CW = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic clr_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i,
  // Level
  output logic [CW-1:0] count_o
);

  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("ifr_fifo: DEPTH must be a power of two, at least 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [CW-1:0] count_q;
  logic push;
  logic pop;

  assign in_ready_o = (count_q != CW'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign out_data_o = mem[rptr_q];
  assign count_o = count_q;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || clr_i) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wptr_q <= wptr_q + AW'(1);
      end
      if (pop) begin
        rptr_q <= rptr_q + AW'(1);
      end
      if (push && !pop) begin
        count_q <= count_q + CW'(1);
      end else if (pop && !push) begin
        count_q <= count_q - CW'(1);
      end
    end
  end

endmodule

module ifr_image_fifo_readout
  import ifr_pkg::*;
#(
  parameter int IMG_DEPTH = 2048,
  parameter int STG_DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Image byte stream from the pipeline
  input wire logic pix_valid_i,
  input wire logic [7:0] pix_data_i,
  output logic pix_ready_o,
  input wire logic vertical_envelope_i,
  // Status sources from neighbouring logic
  input wire logic core_event_flag_i,
  input wire logic host_rdy_i,
  // Indirect register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Status register contents
  output logic [7:0] status_register_o,
  // Pins
  output logic host_irq_o,
  output logic dma_request_line_o,
  output logic dma_request_oe_n_o
);

  localparam int ICW = $clog2(IMG_DEPTH + 1);
  localparam int SCW = $clog2(STG_DEPTH + 1);

  initial begin
    if (IMG_DEPTH > 32768 || IMG_DEPTH < 32) begin
      $error("ifr_image_fifo_readout: IMG_DEPTH out of range");
    end
  end

  // ---------------------------------------------------------------
  // Registers and decode
  // ---------------------------------------------------------------
  ifr_ctrl_s ctrl_q;
  ifr_thr_s thr_q;
  logic [5:0] mask_q;
  logic wr_ctrl;
  logic wr_mask;
  logic wr_ack;
  logic rd_fifo;
  logic flush;
  logic [5:0] flag_ack;

  assign wr_ctrl = reg_wr_i && (reg_addr_i == `IFR_OFF_CTRL);
  assign wr_mask = reg_wr_i && (reg_addr_i == `IFR_OFF_MASK);
  assign wr_ack = reg_wr_i && (reg_addr_i == `IFR_OFF_ACK);
  assign rd_fifo = reg_rd_i && (reg_addr_i == `IFR_OFF_FIFO);
  assign flush = wr_ctrl && reg_wdata_i[`IFR_CTRL_FLUSH];
  assign flag_ack = wr_ack ? (reg_wdata_i[5:0] & `IFR_ACK_MASK) : 6'h00;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ctrl_q <= `IFR_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata_i[`IFR_CTRL_IRQ_POL:`IFR_CTRL_BURST_LO];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      mask_q <= `IFR_MASK_RST;
    end else if (wr_mask) begin
      mask_q <= reg_wdata_i[5:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      thr_q <= `IFR_THR_RST;
    end else if (reg_wr_i && reg_addr_i == `IFR_OFF_THR_LO) begin
      thr_q.blk[3:0] <= reg_wdata_i[7:`IFR_THR_BLK_LO];
      thr_q.force1 <= reg_wdata_i[`IFR_THR_FORCE1];
    end else if (reg_wr_i && reg_addr_i == `IFR_OFF_THR_HI) begin
      thr_q.blk[6:4] <= reg_wdata_i[`IFR_THR_BLK_HI-8:0];
    end
  end

  // ---------------------------------------------------------------
  // Frame envelope and byte path
  // ---------------------------------------------------------------
  logic env_q;
  logic frame_start;
  logic frame_end;
  logic fifo_clear;
  logic stg_valid;
  logic [7:0] stg_data;
  logic img_ready;
  logic img_valid;
  logic [7:0] img_data;
  logic [SCW-1:0] stg_count;
  logic [ICW-1:0] img_count;
  logic [15:0] count16;
  logic pop_img;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      env_q <= 1'b0;
    end else begin
      env_q <= vertical_envelope_i;
    end
  end

  assign frame_start = vertical_envelope_i & ~env_q;
  assign frame_end = ~vertical_envelope_i & env_q;
  assign fifo_clear = frame_start | flush;
  assign pop_img = rd_fifo & img_valid;
  assign count16 = 16'(img_count);

  ifr_fifo #(
    .WIDTH(8),
    .DEPTH(STG_DEPTH)
  ) u_stage (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .clr_i(fifo_clear),
    .in_valid_i(pix_valid_i),
    .in_data_i(pix_data_i),
    .in_ready_o(pix_ready_o),
    .out_valid_o(stg_valid),
    .out_data_o(stg_data),
    .out_ready_i(img_ready),
    .count_o(stg_count)
  );

  ifr_fifo #(
    .WIDTH(8),
    .DEPTH(IMG_DEPTH)
  ) u_image (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .clr_i(fifo_clear),
    .in_valid_i(stg_valid),
    .in_data_i(stg_data),
    .in_ready_o(img_ready),
    .out_valid_o(img_valid),
    .out_data_o(img_data),
    .out_ready_i(pop_img),
    .count_o(img_count)
  );

  // ---------------------------------------------------------------
  // Threshold and status flags
  // ---------------------------------------------------------------
  logic [15:0] thr_eff;
  logic fifo_ready_flag;
  logic leftover;
  logic overflow;
  logic [5:0] sticky_q;
  logic [5:0] set_ev;
  logic [5:0] src;
  logic irq_flag;
  logic xfer_done_q;
  logic dma_done;

  always_comb begin
    if (!vertical_envelope_i || thr_q.force1) begin
      thr_eff = 16'h0001;
    end else begin
      thr_eff = {5'h00, thr_q.blk, 4'h0};
    end
  end

  assign fifo_ready_flag = (count16 >= thr_eff);
  assign leftover = frame_start && (img_count != '0 || stg_count != '0);
  assign overflow = vertical_envelope_i & pix_valid_i & ~pix_ready_o;

  always_comb begin
    set_ev = 6'h00;
    set_ev[`IFR_STS_EOF] = frame_end;
    set_ev[`IFR_STS_SOF] = frame_start;
    set_ev[`IFR_STS_CORE_EVT] = core_event_flag_i;
    set_ev[`IFR_STS_FIFO_ERR] = leftover | overflow;
  end

  // Set beats clear in the same cycle
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sticky_q <= 6'h00;
    end else begin
      sticky_q <= (sticky_q & ~flag_ack) | set_ev;
    end
  end

  always_comb begin
    src = sticky_q;
    src[`IFR_STS_FIFO_RDY] = fifo_ready_flag;
    src[`IFR_STS_RDY] = host_rdy_i;
  end

  assign irq_flag = |(src & mask_q);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      status_register_o <= 8'h00;
    end else begin
      status_register_o <= {irq_flag, 1'b0, src};
    end
  end

  // ---------------------------------------------------------------
  // DMA request sequencing
  // ---------------------------------------------------------------
  ifr_dma_e dma_q;
  logic [5:0] burst_len;
  logic [5:0] burst_cnt_q;
  logic dma_en;

  assign dma_en = (ctrl_q.burst != 2'b00);

  always_comb begin
    case (ctrl_q.burst)
      2'b01: burst_len = `IFR_BURST_LEN_8;
      2'b10: burst_len = `IFR_BURST_LEN_16;
      2'b11: burst_len = `IFR_BURST_LEN_32;
      default: burst_len = `IFR_BURST_LEN_8;
    endcase
  end

  // Burst ends empty after the envelope has closed
  assign dma_done = (dma_q == DMA_BURST) && rd_fifo &&
                    (burst_cnt_q == burst_len - 6'h01) &&
                    (img_count == '0 || (img_count == ICW'(1) && pop_img)) &&
                    !vertical_envelope_i;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || !dma_en || fifo_clear) begin
      dma_q <= DMA_WAIT;
      burst_cnt_q <= 6'h00;
    end else begin
      case (dma_q)
        DMA_WAIT: begin
          if (count16 >= thr_eff && count16 != 16'h0000) begin
            dma_q <= DMA_REQ;
          end
        end
        DMA_REQ: begin
          if (rd_fifo) begin
            dma_q <= DMA_BURST;
            burst_cnt_q <= 6'h01;
          end
        end
        DMA_BURST: begin
          // Reads past the last byte return padding
          if (rd_fifo) begin
            if (burst_cnt_q == burst_len - 6'h01) begin
              dma_q <= DMA_WAIT;
              burst_cnt_q <= 6'h00;
            end else begin
              burst_cnt_q <= burst_cnt_q + 6'h01;
            end
          end
        end
        default: dma_q <= DMA_WAIT;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      xfer_done_q <= 1'b0;
    end else begin
      xfer_done_q <= dma_done | (xfer_done_q & ~flag_ack[`IFR_STS_EOF]);
    end
  end

  // ---------------------------------------------------------------
  // Pins
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      host_irq_o <= 1'b0;
      dma_request_line_o <= 1'b0;
      dma_request_oe_n_o <= 1'b1;
    end else begin
      host_irq_o <= (irq_flag | xfer_done_q) ^ ctrl_q.irq_pol;
      dma_request_line_o <= (dma_q == DMA_REQ) ^ ctrl_q.drq_pol;
      dma_request_oe_n_o <= ~dma_en;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [7:0] last_byte_q;
  logic [7:0] cnt_hi_q;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      last_byte_q <= 8'h00;
    end else if (pop_img) begin
      last_byte_q <= img_data;
    end
  end

  // High count byte is latched with the low byte read
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cnt_hi_q <= 8'h00;
    end else if (reg_rd_i && reg_addr_i == `IFR_OFF_CNT_LO) begin
      cnt_hi_q <= count16[15:8];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `IFR_OFF_FIFO: reg_rdata_o <= pop_img ? img_data : last_byte_q;
        `IFR_OFF_CTRL: reg_rdata_o <= {2'b00, ctrl_q, 2'b00};
        `IFR_OFF_MASK: reg_rdata_o <= {2'b00, mask_q};
        `IFR_OFF_THR_LO: reg_rdata_o <= {thr_q.blk[3:0], 3'b000,
                                         thr_q.force1};
        `IFR_OFF_THR_HI: reg_rdata_o <= {5'h00, thr_q.blk[6:4]};
        `IFR_OFF_CNT_LO: reg_rdata_o <= count16[7:0];
        `IFR_OFF_CNT_HI: reg_rdata_o <= cnt_hi_q;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

endmodule

// ---- logic/ifr_map.svh ----
`ifndef IFR_MAP_SVH
`define IFR_MAP_SVH

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define IFR_OFF_FIFO 3'h0
`define IFR_OFF_CTRL 3'h1
`define IFR_OFF_MASK 3'h2
`define IFR_OFF_ACK 3'h3
`define IFR_OFF_THR_LO 3'h4
`define IFR_OFF_THR_HI 3'h5
`define IFR_OFF_CNT_LO 3'h6
`define IFR_OFF_CNT_HI 3'h7

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define IFR_CTRL_IRQ_POL 5
`define IFR_CTRL_DRQ_POL 4
`define IFR_CTRL_BURST_HI 3
`define IFR_CTRL_BURST_LO 2
`define IFR_CTRL_FLUSH 0
`define IFR_THR_BLK_HI 10
`define IFR_THR_BLK_LO 4
`define IFR_THR_FORCE1 0
`define IFR_STS_IRQ 7
`define IFR_STS_EOF 5
`define IFR_STS_SOF 4
`define IFR_STS_CORE_EVT 3
`define IFR_STS_FIFO_ERR 2
`define IFR_STS_FIFO_RDY 1
`define IFR_STS_RDY 0
`define IFR_ACK_MASK 6'h3C

// -----------------------------------------------------------------
// Reset values and counts
// -----------------------------------------------------------------
`define IFR_CTRL_RST 4'h0
`define IFR_MASK_RST 6'h00
`define IFR_THR_RST 8'h00
`define IFR_BURST_LEN_8 6'h08
`define IFR_BURST_LEN_16 6'h10
`define IFR_BURST_LEN_32 6'h20

`endif

// ---- logic/ifr_pkg.sv ----
package ifr_pkg;

  // Transfer control fields
  typedef struct packed {
    logic irq_pol;
    logic drq_pol;
    logic [1:0] burst;
  } ifr_ctrl_s;

  // Threshold fields
  typedef struct packed {
    logic [6:0] blk;
    logic force1;
  } ifr_thr_s;

  // DMA request sequencing
  typedef enum logic [1:0] {
    DMA_WAIT,
    DMA_REQ,
    DMA_BURST
  } ifr_dma_e;

endpackage

// ---- tb/ifr_dma_host_model.sv ----
`timescale 1ns/100ps
module ifr_dma_host_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Request pin and setup
  input wire logic drq_i,
  input wire logic drq_oe_n_i,
  input wire logic drq_pol_i,
  input wire logic [5:0] burst_len_i,
  input wire logic [3:0] gap_i,
  // Read strobe towards the FIFO register
  output logic rd_o,
  output int reads_o
);
  logic act_q;
  wire act = !drq_oe_n_i && (drq_i ^ drq_pol_i);

  initial begin
    rd_o = 1'b0;
    reads_o = 0;
    act_q = 1'b0;
    forever begin
      @(negedge mclk_i);
      if (sys_rst_i) begin
        act_q = 1'b0;
      end else begin
        // One whole burst per request edge
        if (act && !act_q) begin
          repeat (gap_i) @(negedge mclk_i);
          for (int i = 0; i < burst_len_i; i++) begin
            rd_o = 1'b1; // address kept on the FIFO
            reads_o++;
            @(negedge mclk_i);
          end
          rd_o = 1'b0;
        end
        act_q = act;
      end
    end
  end
endmodule

// ---- tb/ifr_readout_props.sv ----
`timescale 1ns/100ps
`include "ifr_map.svh"
module ifr_readout_props (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Stream and frame
  input wire logic pix_valid_i,
  input wire logic pix_ready_o,
  input wire logic vertical_envelope_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // Status and pins
  input wire logic [7:0] status_register_o,
  input wire logic dma_request_line_o,
  input wire logic dma_request_oe_n_o
);
  // ----------------------------------------
  // Mirror of written control and mask
  // ----------------------------------------
  logic [3:0] ctl_q;
  logic [5:0] msk_q;
  logic clr_q;
  wire clr_w = reg_wr_i && reg_addr_i == `IFR_OFF_ACK && reg_wdata_i[2];
  wire drq_act = dma_request_line_o ^ ctl_q[2];
  wire fifo_rd = reg_rd_i && reg_addr_i == `IFR_OFF_FIFO;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ctl_q <= 4'h0;
      msk_q <= 6'h00;
    end else if (reg_wr_i && reg_addr_i == `IFR_OFF_CTRL) begin
      ctl_q <= reg_wdata_i[5:2];
    end else if (reg_wr_i && reg_addr_i == `IFR_OFF_MASK) begin
      msk_q <= reg_wdata_i[5:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    clr_q <= !sys_rst_i && clr_w;
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_off3; (ctl_q[1:0] == 2'h0)[*3]; endsequence
  sequence s_on3; (ctl_q[1:0] != 2'h0)[*3]; endsequence
  sequence s_drop; pix_valid_i && !pix_ready_o && vertical_envelope_i;
  endsequence
  sequence s_first_pop; !dma_request_oe_n_o && drq_act && fifo_rd;
  endsequence
  sequence s_msk_held; $stable(msk_q)[*3]; endsequence

  a_oe_floats_off: assert property (s_off3 |-> dma_request_oe_n_o)
    else $error("request pin driven while DMA is off");
  a_oe_drives_on: assert property (s_on3 |-> !dma_request_oe_n_o)
    else $error("request pin floating while DMA is on");
  a_ctrl_reads_zero: assert property (reg_rd_i &&
    reg_addr_i == `IFR_OFF_CTRL |=> reg_rdata_o[1:0] == 2'h0)
    else $error("control flush bit read back nonzero");
  a_err_on_drop: assert property (s_drop |-> ##[1:4]
    status_register_o[`IFR_STS_FIFO_ERR]) else $error("overflow left no error");
  a_err_stays_set: assert property (status_register_o[2] &&
    !clr_w && !clr_q |=> status_register_o[2])
    else $error("error flag dropped without a clear");
  a_sof_on_rise: assert property ($rose(vertical_envelope_i)
    |-> ##[1:3] status_register_o[`IFR_STS_SOF])
    else $error("envelope start not flagged");
  a_irq_flag_set: assert property (s_msk_held ##0
    (|(status_register_o[5:0] & msk_q)) |-> ##[0:1] status_register_o[7])
    else $error("enabled source did not raise the flag");
  a_drq_released: assert property (s_first_pop |-> ##[1:3] !drq_act)
    else $error("request held after first burst read");
endmodule

bind ifr_image_fifo_readout ifr_readout_props u_ifr_readout_props (
  .mclk_i, .sys_rst_i, .pix_valid_i, .pix_ready_o, .vertical_envelope_i,
  .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
  .status_register_o, .dma_request_line_o, .dma_request_oe_n_o);

// ---- tb/test_image_fifo_host_readout.sv ----
`timescale 1ns/100ps
module test_image_fifo_host_readout;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pv = 1'b0;
  logic [7:0] pd = 8'h00;
  logic env = 1'b0;
  logic evt = 1'b0;
  logic hrdy = 1'b0;
  logic twr = 1'b0;
  logic trd = 1'b0;
  logic [2:0] tadr = 3'h0;
  logic [7:0] twd = 8'h00;
  logic pol = 1'b0;
  logic [3:0] gap = 4'h0;
  logic drd;
  logic [7:0] rdata;
  logic [7:0] sts;
  logic irq;
  logic dma_request_line;
  logic oe_n;
  logic [7:0] d;
  int dma_n;
  int len = 8;
  int n0;
  int np;
  int cyc = 0;
  int failures = 0;
  int n_compared = 0;

  always #2 clk = ~clk;

  ifr_image_fifo_readout #(.IMG_DEPTH(64), .STG_DEPTH(16))
    u_ifr_image_fifo_readout (
    .mclk_i(clk), .sys_rst_i(rst), .pix_valid_i(pv), .pix_data_i(pd),
    .pix_ready_o(), .vertical_envelope_i(env), .core_event_flag_i(evt),
    .host_rdy_i(hrdy), .reg_wr_i(twr), .reg_rd_i(trd | drd),
    .reg_addr_i(drd ? 3'h0 : tadr), .reg_wdata_i(twd),
    .reg_rdata_o(rdata), .status_register_o(sts), .host_irq_o(irq),
    .dma_request_line_o(dma_request_line), .dma_request_oe_n_o(oe_n));

  ifr_dma_host_model u_ifr_dma_host_model (
    .mclk_i(clk), .sys_rst_i(rst), .drq_i(dma_request_line), .drq_oe_n_i(oe_n),
    .drq_pol_i(pol), .burst_len_i(len[5:0]), .gap_i(gap),
    .rd_o(drd), .reads_o(dma_n));

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    tadr = a;
    twd = v; // write data for the register at offset a
    twr = 1'b1;
    @(negedge clk);
    twr = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    tadr = a;
    trd = 1'b1;
    @(negedge clk);
    trd = 1'b0;
    @(negedge clk);
    v = rdata;
  endtask

  task automatic cnt_chk(input logic [15:0] e);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(3'h6, lo);
    rd(3'h7, hi);
    check({hi, lo}, e);
  endtask

  task automatic st(input int b, input logic e);
    repeat (2) @(negedge clk);
    check(sts[b], e);
  endtask

  task automatic push(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      pv = 1'b1;
      pd = base + i[7:0];
      @(negedge clk);
    end
    pv = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  task automatic final_report;
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    for (int a = 1; a < 6; a++) begin
      rd(a[2:0], d);
      check(d, 0);
    end
    cnt_chk(0);
    push(3, 8'hA0);
    cnt_chk(3);
    for (int i = 0; i < 4; i++) begin
      rd(3'h0, d);
      check(d, 8'hA0 + (i > 2 ? 2 : i));
    end
    cnt_chk(0);
    push(5, 8'h10);
    wr(3'h1, 8'h00);
    cnt_chk(5);
    wr(3'h1, 8'h01);
    cnt_chk(0);
    push(2, 8'h20);
    env = 1'b1;
    @(negedge clk);
    cnt_chk(0);
    st(2, 1'b1);
    wr(3'h3, 8'h38);
    st(2, 1'b1);
    check(sts[4], 0);
    wr(3'h3, 8'h04);
    st(2, 1'b0);
    wr(3'h4, 8'h10);
    rd(3'h4, d);
    check(d, 8'h10);
    push(15, 8'h00);
    st(1, 1'b0);
    push(1, 8'h00);
    st(1, 1'b1);
    rd(3'h0, d);
    st(1, 1'b0);
    wr(3'h4, 8'h11);
    st(1, 1'b1);
    wr(3'h4, 8'h10);
    st(1, 1'b0);
    env = 1'b0;
    st(1, 1'b1);
    env = 1'b1;
    repeat (3) @(negedge clk);
    wr(3'h3, 8'h3C);
    push(90, 8'h00);
    st(2, 1'b1);
    cnt_chk(64);
    st(2, 1'b1);
    wr(3'h3, 8'h04);
    st(2, 1'b0);
    wr(3'h1, 8'h01);
    wr(3'h3, 8'h3C);
    wr(3'h2, 8'h37);
    evt = 1'b1;
    @(negedge clk);
    evt = 1'b0;
    st(7, 1'b0);
    check(irq, 0);
    hrdy = 1'b1;
    st(7, 1'b1);
    check(irq, 1);
    hrdy = 1'b0;
    wr(3'h2, 8'h08);
    st(7, 1'b1);
    check(irq, 1);
    wr(3'h1, 8'h20);
    st(3, 1'b1);
    check(irq, 0);
    wr(3'h3, 8'h08); // acknowledge after the status read
    st(3, 1'b0);
    check(irq, 1);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h00);
    env = 1'b0;
    wr(3'h4, 8'h20); // two blocks, not below any burst
    for (int b = 1; b < 4; b++) begin
      len = 8 << (b - 1);
      np = (b == 1) ? 5 : len;
      n0 = dma_n;
      push(np, 8'h40);
      pol = (b == 3);
      gap = (b == 2) ? 4'h3 : 4'h0;
      wr(3'h1, {3'b000, pol, b[1:0], 2'b00});
      repeat (3 * len + 20) @(negedge clk);
      check(oe_n, 0);
      check(dma_n - n0, len);
      check(rdata, 8'h3F + np);
      check(irq, 1);
      cnt_chk(0);
      wr(3'h1, 8'h00);
      wr(3'h3, 8'h20);
      repeat (2) @(negedge clk);
      check(irq, 0);
      check(oe_n, 1);
    end
    final_report();
  end
endmodule
